// >>> pt_far_model.sv
// far-side model: serial port shift clock and the shared pwm time base
`timescale 1ns/1ps
module pt_far_model
  import pt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic shift_tick_i,
  input wire pt_tbase_t tbase_i,
  output logic [15:0] shift_cnt_o,
  output logic [15:0] match_cnt_o,
  output logic shift_clk_o
);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shift_cnt_o <= 16'h0000;
      shift_clk_o <= 1'b0;
    end else if (shift_tick_i) begin
      shift_cnt_o <= shift_cnt_o + 16'h0001;
      shift_clk_o <= ~shift_clk_o;
    end
  end
  // both pwm units see one period
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      match_cnt_o <= 16'h0000;
    end else if (tbase_i.match) begin
      match_cnt_o <= match_cnt_o + 16'h0001;
    end
  end
endmodule // pt_far_model

// >>> pt_pkg.sv
// shared constants, field layouts and carrier types of the period timer
package pt_pkg;

  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_COUNT = 8'h11;
  localparam logic [7:0] IDX_CTRL = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_PERIOD = 8'h92;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic ENABLE_RST = 1'b0;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned FLAG_MATCH_BIT = 1;
  localparam int unsigned EN_MATCH_BIT = 1;

  // ****************************************
  // input divider encodings and counter limits
  // ****************************************
  localparam logic [1:0] IDS_DIV1 = 2'h0;
  localparam logic [1:0] IDS_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LIM_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LIM_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LIM_DIV16 = 4'hF;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [3:0] match_div_sel;
    logic counter_run;
    logic [1:0] input_div_sel;
  } pt_ctrl_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic match;
  } pt_tbase_t;

  // last prescaler count before a tick; upper select bit forces 1:16
  function automatic logic [3:0] pt_pre_limit(input logic [1:0] sel);
    if (sel[1]) begin
      return PRE_LIM_DIV16;
    end else if (sel == IDS_DIV4) begin
      return PRE_LIM_DIV4;
    end
    return PRE_LIM_DIV1;
  endfunction

endpackage

// >>> pt_postscaler.sv
// match postscaler dividing period matches by 1 to 16
`timescale 1ns/1ps
module pt_postscaler
  import pt_pkg::*;
#(
  parameter int unsigned CNT_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic match_i,
  input wire logic [CNT_W-1:0] sel_i,
  output logic event_o
);

  logic [CNT_W-1:0] cnt_q;

  assign event_o = en_i && !clr_i && match_i && (cnt_q >= sel_i);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (en_i) begin
      if (clr_i || (match_i && cnt_q >= sel_i)) begin
        cnt_q <= '0;
      end else if (match_i) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_POST_STEP: assert property (
    en_i && !clr_i && match_i && cnt_q < sel_i |=> cnt_q == $past(cnt_q) + CNT_W'(1)
  ) else $error("postscaler did not advance");

  AST_POST_CLR: assert property (
    en_i && clr_i |-> !event_o ##1 cnt_q == '0
  ) else $error("postscaler not cleared");

endmodule // pt_postscaler

// >>> pt_prescaler.sv
// input prescaler dividing the instruction clock by 1, 4 or 16
`timescale 1ns/1ps
module pt_prescaler
  import pt_pkg::*;
#(
  parameter int unsigned CNT_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(pt_pre_limit(sel_i));
  assign tick_o = en_i && run_i && !clr_i && (cnt_q >= limit);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (en_i) begin
      if (clr_i || (run_i && cnt_q >= limit)) begin
        cnt_q <= '0;
      end else if (run_i) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_PRESC_DIV4: assert property (
    tick_o && sel_i == IDS_DIV4 ##1 (en_i && run_i && !clr_i && sel_i == IDS_DIV4) [*4]
    |-> tick_o
  ) else $error("prescaler 1:4 tick missing");

  AST_PRESC_CLR: assert property (
    en_i && clr_i |=> cnt_q == '0
  ) else $error("prescaler not cleared");

endmodule // pt_prescaler

// >>> pt_timer_top.sv
// period timer with scalers behind an axi4-lite register slave
`timescale 1ns/1ps

// Operation
// - 8-bit count register, read/write, cleared to zero by every reset.
// - count clock is instruction clock through prescaler 1, 4 or 16.
// - count increments per tick; on equal to limit next tick returns to zero.
// - 8-bit period limit register, read/write, reset to FFh.
// - matches counted by 4-bit postscaler giving one event per chosen count.
// - match divider select bits 6:3 give ratio of value plus one.
// - run bit 2 enables counting; clear stops the timer.
// - postscaler event sets flag bit 1; enable sits in enables bit 1.
// - scalers cleared by count write, control write and any reset.
// - control write keeps count value but clears scalers.
// - unscaled match pulse goes out to the serial port.
// - count and match are offered as the PWM time base.
// - both PWM units share this time base and its update event.
module pt_timer_top
  import pt_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned POST_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic ssp_shift_tick_o,
  output pt_tbase_t pwm_timebase_o,
  output logic period_event_o,
  output logic period_match_flag_o,
  output logic period_match_irq_enable_o
);

  // ****************************************
  // address decode helpers
  // ****************************************
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[ADDR_W-1:10] != '0) begin
      return 1'b0;
    end
    return idx == IDX_INTCTL || idx == IDX_FLAGS || idx == IDX_COUNT ||
           idx == IDX_CTRL || idx == IDX_ENABLES || idx == IDX_PERIOD;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] intctl_q;
  logic [7:0] count_q;
  logic [7:0] period_q;
  pt_ctrl_t ctrl_q;
  logic flag_q;
  logic irq_en_q;
  logic match_q;
  logic event_q;

  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_ok;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_per;
  logic wr_flags;
  logic wr_en_reg;
  logic wr_intctl;
  logic scaler_clr;
  logic pre_tick;
  logic match_now;
  logic post_event;
  logic rd_go;
  logic [7:0] rd_val;

  // ****************************************
  // axi4-lite write channels
  // ****************************************
  assign s_axi_awready_o = clk_en_i && !aw_have_q && !bvalid_q;
  assign s_axi_wready_o = clk_en_i && !w_have_q && !bvalid_q;
  assign wr_go = clk_en_i && aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = reg_index(aw_addr_q);
  assign wr_ok = wr_go && is_mapped(aw_addr_q) && w_lane_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awready_o && s_axi_awvalid_i) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_lane_q <= 1'b0;
    end else if (s_axi_wready_o && s_axi_wvalid_i) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata_i[7:0];
      w_lane_q <= s_axi_wstrb_i[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // ****************************************
  // axi4-lite read channels
  // ****************************************
  assign s_axi_arready_o = clk_en_i && !rvalid_q;
  assign rd_go = s_axi_arready_o && s_axi_arvalid_i;

  always_comb begin
    rd_val = 8'h00;
    unique case (reg_index(s_axi_araddr_i))
      IDX_INTCTL: rd_val = intctl_q;
      IDX_FLAGS: rd_val = 8'(flag_q) << FLAG_MATCH_BIT;
      IDX_COUNT: rd_val = count_q;
      IDX_CTRL: rd_val = {1'b0, ctrl_q};
      IDX_ENABLES: rd_val = 8'(irq_en_q) << EN_MATCH_BIT;
      IDX_PERIOD: rd_val = period_q;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= is_mapped(s_axi_araddr_i) ? {24'h000000, rd_val} : 32'h00000000;
      rresp_q <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (clk_en_i && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // ****************************************
  // register write strobes
  // ****************************************
  assign wr_cnt = wr_ok && wr_idx == IDX_COUNT;
  assign wr_ctrl = wr_ok && wr_idx == IDX_CTRL;
  assign wr_per = wr_ok && wr_idx == IDX_PERIOD;
  assign wr_flags = wr_ok && wr_idx == IDX_FLAGS;
  assign wr_en_reg = wr_ok && wr_idx == IDX_ENABLES;
  assign wr_intctl = wr_ok && wr_idx == IDX_INTCTL;
  // scaler clear; control write leaves count
  assign scaler_clr = wr_cnt || wr_ctrl;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      intctl_q <= INTCTL_RST;
    end else if (clk_en_i && wr_intctl) begin
      intctl_q <= w_data_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= pt_ctrl_t'(CTRL_RST);
    end else if (clk_en_i && wr_ctrl) begin
      ctrl_q <= pt_ctrl_t'(w_data_q[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      period_q <= PERIOD_RST;
    end else if (clk_en_i && wr_per) begin
      period_q <= w_data_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_en_q <= ENABLE_RST;
    end else if (clk_en_i && wr_en_reg) begin
      irq_en_q <= w_data_q[EN_MATCH_BIT];
    end
  end

  // ****************************************
  // scalers
  // ****************************************
  pt_prescaler #(
    .CNT_W(4)
  ) u_pre (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en_i),
    .clr_i(scaler_clr),
    .run_i(ctrl_q.counter_run),
    .sel_i(ctrl_q.input_div_sel),
    .tick_o(pre_tick)
  );

  assign match_now = pre_tick && (count_q == period_q);

  pt_postscaler #(
    .CNT_W(POST_W)
  ) u_post (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en_i),
    .clr_i(scaler_clr),
    .match_i(match_now),
    .sel_i(POST_W'(ctrl_q.match_div_sel)),
    .event_o(post_event)
  );

  // ****************************************
  // counter
  // ****************************************
  // count register, increment and wrap
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_q <= COUNT_RST;
    end else if (clk_en_i) begin
      if (wr_cnt) begin
        count_q <= w_data_q;
      end else if (match_now) begin
        count_q <= COUNT_RST;
      end else if (pre_tick) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flag_q <= FLAG_RST;
    end else if (clk_en_i) begin
      if (post_event) begin
        flag_q <= 1'b1;
      end else if (wr_flags) begin
        flag_q <= w_data_q[FLAG_MATCH_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      match_q <= 1'b0;
      event_q <= 1'b0;
    end else if (clk_en_i) begin
      match_q <= match_now;
      event_q <= post_event;
    end
  end

  // ****************************************
  // outputs to partner units
  // ****************************************
  // unscaled match to serial port
  assign ssp_shift_tick_o = match_q;
  assign pwm_timebase_o = '{count: count_q, period: period_q, match: match_q};
  assign period_event_o = event_q;
  assign period_match_flag_o = flag_q;
  assign period_match_irq_enable_o = irq_en_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_COUNT_RESET: assert property (
    disable iff (1'b0) !rst_n_i |=> count_q == 8'h00
  ) else $error("count not cleared by reset");

  AST_PERIOD_RESET: assert property (
    disable iff (1'b0) !rst_n_i |=> period_q == 8'hFF
  ) else $error("period limit not FFh after reset");

  AST_WRAP: assert property (
    clk_en_i && pre_tick && !wr_cnt && count_q == period_q |=> count_q == 8'h00 ##0 match_q
  ) else $error("counter did not wrap on match");

  AST_INCREMENT: assert property (
    clk_en_i && pre_tick && !wr_cnt && count_q != period_q
    |=> count_q == $past(count_q) + 8'h01
  ) else $error("counter did not increment");

  AST_STOPPED: assert property (
    !ctrl_q.counter_run && clk_en_i && !wr_cnt |=> $stable(count_q) ##0 !match_q
  ) else $error("stopped timer moved");

  AST_NO_MATCH_IDLE: assert property (
    !ctrl_q.counter_run || !clk_en_i |-> !pre_tick && !post_event
  ) else $error("match without tick");

  AST_FLAG_SET: assert property (
    clk_en_i && post_event |=> flag_q && period_event_o
  ) else $error("flag not set by postscaler event");

  AST_CTRL_KEEPS_COUNT: assert property (
    clk_en_i && wr_ctrl |=> $stable(count_q) ##0 !match_q
  ) else $error("control write changed count");

  AST_SSP_PULSE: assert property (
    clk_en_i && match_now |=> ssp_shift_tick_o && pwm_timebase_o.match
  ) else $error("serial port pulse missing");

  AST_B_HOLD: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)
  ) else $error("write answer dropped");

  COV_WRAP: cover property (match_now && period_q != 8'hFF);
  COV_EVENT: cover property (post_event && ctrl_q.match_div_sel != 4'h0);
  COV_CTRL_WR: cover property (wr_ctrl ##1 s_axi_bvalid_o);
  COV_READ: cover property (rd_go ##1 s_axi_rvalid_o);

endmodule // pt_timer_top

// >>> tb.sv
// self-checking bench of the period timer
`timescale 1ns/1ps
module tb;
  import pt_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] rst;
    logic [1:0] resp;
  } pt_row_t;
  logic core_clk_i, rst_n_i, clk_en_i;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, cnt0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic ssp_tick, ev, flag, irq_en, shift_clk;
  pt_tbase_t tbase;
  logic [15:0] shift_cnt, match_cnt, held;
  int err_count, checks_done, cycles, n;
  pt_row_t rows [7] = '{
    '{IDX_INTCTL, 8'hA5, 8'hA5, INTCTL_RST, RESP_OKAY},
    '{IDX_ENABLES, 8'hFF, 8'h02, 8'h00, RESP_OKAY},
    '{IDX_PERIOD, 8'h3C, 8'h3C, PERIOD_RST, RESP_OKAY},
    '{IDX_COUNT, 8'h5A, 8'h5A, COUNT_RST, RESP_OKAY},
    '{IDX_CTRL, 8'hF3, 8'h73, 8'h00, RESP_OKAY},
    '{IDX_FLAGS, 8'hFD, 8'h00, 8'h00, RESP_OKAY},
    '{8'h20, 8'h11, 8'h00, 8'h00, RESP_SLVERR}
  };

  pt_timer_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ssp_shift_tick_o(ssp_tick),
    .pwm_timebase_o(tbase), .period_event_o(ev), .period_match_flag_o(flag),
    .period_match_irq_enable_o(irq_en));

  pt_far_model u_far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .shift_tick_i(ssp_tick),
    .tbase_i(tbase), .shift_cnt_o(shift_cnt), .match_cnt_o(match_cnt),
    .shift_clk_o(shift_clk));

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic ap, wp, bp;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    @(posedge core_clk_i);
    awaddr <= {2'b00, idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bp) begin
      @(posedge core_clk_i);
      if (ap && awready === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bp = 1'b0;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d);
    logic ap, dp;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge core_clk_i);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (dp) begin
      @(posedge core_clk_i);
      if (ap && arready === 1'b1) begin
        ap = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        dp = 1'b0;
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  // edges from one match pulse to the next
  task automatic gap(output int c);
    c = 0;
    do @(posedge core_clk_i); while (ssp_tick !== 1'b1);
    do begin
      @(posedge core_clk_i);
      c++;
    end while (ssp_tick !== 1'b1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n_i, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    clk_en_i = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h1;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].idx, {24'h0, rows[i].wd}, resp);
      check({30'h0, resp}, {30'h0, rows[i].resp});
      rd_reg(rows[i].idx, rd);
      check(rd, {24'h0, rows[i].rd});
      check({30'h0, resp}, {30'h0, rows[i].resp});
    end
    check({31'h0, irq_en}, 32'h1);
    $display("register table done");
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_reg(rows[i].idx, rd);
      check(rd, {24'h0, rows[i].rst});
    end
    check({24'h0, tbase.period}, {24'h0, PERIOD_RST});
    $display("reset values done");
    wr(IDX_PERIOD, 32'h2, resp);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CTRL, {29'h0, 1'b1, s[1:0]}, resp);
      gap(n);
      check(n, (s == 0) ? 3 : (s == 1) ? 12 : 48);
      check({24'h0, tbase.count}, 32'h0);
    end
    $display("prescaler done");
    wr(IDX_PERIOD, 32'h1, resp);
    foreach (rows[k]) begin
      if (k < 3) begin
        wr(IDX_CTRL, {25'h0, (k == 0) ? 4'h0 : (k == 1) ? 4'h2 : 4'hF, 3'b100}, resp);
        do @(posedge core_clk_i); while (ev !== 1'b1);
        n = 0;
        do begin
          @(posedge core_clk_i);
          n += (ssp_tick === 1'b1);
        end while (ev !== 1'b1);
        check(n, (k == 0) ? 1 : (k == 1) ? 3 : 16);
      end
    end
    wr(IDX_CTRL, 32'h0, resp);
    rd_reg(IDX_FLAGS, rd);
    check(rd, 32'h2);
    check({31'h0, flag}, 32'h1);
    wr(IDX_FLAGS, 32'h0, resp);
    rd_reg(IDX_FLAGS, rd);
    check(rd, 32'h0);
    $display("postscaler done");
    rd_reg(IDX_COUNT, cnt0);
    held = shift_cnt;
    repeat (40) @(posedge core_clk_i);
    rd_reg(IDX_COUNT, rd);
    check(rd, cnt0);
    check({31'h0, shift_clk}, {31'h0, shift_cnt[0]});
    check({16'h0, shift_cnt}, {16'h0, held});
    check({16'h0, match_cnt}, {16'h0, shift_cnt});
    wr(IDX_COUNT, 32'h37, resp);
    wr(IDX_CTRL, 32'h78, resp);
    rd_reg(IDX_COUNT, rd);
    check(rd, 32'h37);
    wstrb <= 4'h0;
    wr(IDX_PERIOD, 32'h55, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    wstrb <= 4'h1;
    rd_reg(IDX_PERIOD, rd);
    check(rd, 32'h1);
    wr(IDX_CTRL, 32'h4, resp);
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    @(posedge core_clk_i);
    held = {8'h00, tbase.count};
    repeat (10) @(posedge core_clk_i);
    check({24'h0, tbase.count}, {16'h0, held});
    clk_en_i <= 1'b1;
    $display("stop and control write done");
    summarize();
  end
endmodule // tb
